// ### sdc_defs.svh
// constants for the conversion sequencer: offsets, fields, resets, timing
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

// clock and documented times, each in nanoseconds
`define SDC_CLK_PERIOD_NS     5
`define SDC_CONV_PERIOD_NS    8000000
`define SDC_SETTLE_NS         24000000
`define SDC_OSC_START_NS      1000000
`define SDC_PRE_UPDATE_NS     1000

// output word layout
`define SDC_RESULT_W          12
`define SDC_WORD_W            24
`define SDC_PAD_BITS          4'h0
`define SDC_PATTERN           3'h5
// identity value is arbitrary, chosen only to be non-zero
`define SDC_IDENTITY          2'h2

// register byte offsets
`define SDC_REG_STATUS        8'h00
`define SDC_REG_MASK          8'h04
`define SDC_REG_RESULT        8'h08
`define SDC_REG_STATE         8'h0C

// status bit positions
`define SDC_ST_NEW            0
`define SDC_ST_READ           1
`define SDC_ST_OVERRUN        2
`define SDC_ST_RANGE          3

// reset values
`define SDC_STATUS_RST        4'h0
`define SDC_MASK_RST          4'h0
`define SDC_RESULT_RST        12'h800

`endif

// ### sdc_pkg.sv
// types shared by the conversion sequencer files
`default_nettype none
package sdc_pkg;
  // sequencer phases after the power-down pin
  typedef enum logic [1:0] {ST_OFF, ST_OSC_WAIT, ST_CONVERT} seq_state_e;
  // one conversion code
  typedef logic [11:0] code_t;
  // one serial output word
  typedef logic [23:0] word_t;
  // interrupt event group
  typedef logic [3:0]  event_t;
endpackage
`default_nettype wire

// ### sdc_shift_if.sv
// link between the sequencer and its serial word shifter
`timescale 1ns/1ps
`default_nettype none
interface sdc_shift_if;
  logic          load;      // capture a new word
  sdc_pkg::word_t word;     // word to capture
  logic          clear;     // drop any transfer in progress
  logic          sclk_fall; // filtered serial clock falling edge
  logic          sclk_rise; // filtered serial clock rising edge
  logic          bit_out;   // bit now presented
  logic          busy;      // transfer under way
  logic          done;      // pulse, whole word taken by host
  modport seq (output load, word, clear, sclk_fall, sclk_rise, input bit_out, busy, done);
  modport shifter (input load, word, clear, sclk_fall, sclk_rise, output bit_out, busy, done);
endinterface
`default_nettype wire

// ### sdc_word_shifter.sv
// serial word shifter: one bit per serial clock falling edge, msb first
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_word_shifter (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  sdc_shift_if.shifter    sh
);
  import sdc_pkg::*;

  word_t      word_q;   // remaining bits, next one at the top
  logic [4:0] count_q;  // bits presented so far
  logic       bit_q;    // bit on the line
  logic       busy_q;   // transfer under way
  logic       done_q;   // one-cycle completion pulse

  // whole word presented, waiting for the last sampling edge
  logic       last_bit;
  assign last_bit = (count_q == 5'(`SDC_WORD_W));

  // shift engine; a load outranks a clear so a fresh word is never lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_q  <= '0;
      count_q <= 5'h00;
      bit_q   <= 1'b1;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (sh.load) begin
        // new word, transfer restarts from the msb
        word_q  <= sh.word;
        count_q <= 5'h00;
        busy_q  <= 1'b0;
      end else if (sh.clear) begin
        // interface reset, partial transfer abandoned
        count_q <= 5'h00;
        busy_q  <= 1'b0;
      end else if (sh.sclk_fall && !last_bit) begin
        // next bit goes out on the falling edge
        bit_q   <= word_q[`SDC_WORD_W-1];
        word_q  <= {word_q[`SDC_WORD_W-2:0], 1'b0};
        count_q <= count_q + 5'h01;
        busy_q  <= 1'b1;
      end else if (sh.sclk_rise && last_bit && busy_q) begin
        // host has sampled the lsb
        busy_q  <= 1'b0;
        done_q  <= 1'b1;
        count_q <= 5'h00;
      end
    end
  end

  assign sh.bit_out = bit_q;
  assign sh.busy    = busy_q;
  assign sh.done    = done_q;
endmodule // sdc_word_shifter
`default_nettype wire

// ### sigma_delta_conversion_sequencer.sv
// control logic of a 12-bit sigma-delta converter: pacing, power-down, serial output
//
// Summary of operation
// - one new result every 8 ms
// - first result only after 24 ms settling
// - every conversion overwrites the result register
// - power-down stops oscillator, tristates data/ready
// - power-down pin clears all logic state; the shifter word and bit registers and pin synchronisers keep their values
// - wait 1 ms oscillator start before sampling
// - data/ready driven high until first result
// - same reset performed automatically at power-up
// - results coded as offset binary
// - code is 2^11 times (ratio plus one)
// - data/ready falls when new result available
// - 24-bit word: result, four zeros, status
// - ready returns high after read or before update
// - status pattern bits read 101
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.svh"
module sigma_delta_conversion_sequencer #(
  parameter int unsigned CONV_CYCLES   = `SDC_CONV_PERIOD_NS / `SDC_CLK_PERIOD_NS,
  parameter int unsigned SETTLE_CYCLES = `SDC_SETTLE_NS / `SDC_CLK_PERIOD_NS,
  parameter int unsigned OSC_CYCLES    = `SDC_OSC_START_NS / `SDC_CLK_PERIOD_NS
) (
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           clk_en,
  input  wire logic           power_down_reset_n,
  input  wire logic           sclk,
  output logic                dout_rdy_o,
  output logic                dout_rdy_oe,
  input  wire sdc_pkg::code_t filt_data,
  input  wire logic           filt_range_err,
  output logic                osc_en,
  output logic                mod_run,
  output logic                dsp_clear,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [31:0]         reg_rdata,
  output logic                irq
);
  import sdc_pkg::*;

  // conversions that make up the settling time
  localparam int unsigned SETTLE_CONV = SETTLE_CYCLES / CONV_CYCLES;
  // margin before an update in which an unread result is withdrawn
  localparam int unsigned PRE_CYCLES  = `SDC_PRE_UPDATE_NS / `SDC_CLK_PERIOD_NS;
  // timer compare points at counter width
  localparam logic [22:0] CONV_LAST   = 23'(CONV_CYCLES - 1);
  localparam logic [22:0] OSC_LAST    = 23'(OSC_CYCLES - 1);
  localparam logic [22:0] PRE_POINT   = 23'(CONV_CYCLES - 1 - PRE_CYCLES);
  localparam logic [3:0]  SETTLE_LAST = 4'(SETTLE_CONV - 1);

  // two's complement filter output to offset binary
  // half scale offset
  function automatic code_t to_offset_binary(input code_t twos);
    // flipping the msb adds half scale: 2^11 * (ratio + 1)
    return {~twos[`SDC_RESULT_W-1], twos[`SDC_RESULT_W-2:0]};
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] pin_s1_q;   // first stage, read only by second stage
  logic [1:0] pin_s2_q;   // second stage
  logic [1:0] pin_s3_q;   // third stage
  logic [1:0] pin_f_q;    // filtered pin levels
  logic [1:0] pin_raw;    // {sclk, power-down pin}

  assign pin_raw = {sclk, power_down_reset_n};

  // three flops; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // serial clock bit starts at its idle high level, power-down bit low
      pin_s1_q <= 2'h2;
      pin_s2_q <= 2'h2;
      pin_s3_q <= 2'h2;
      pin_f_q  <= 2'h2;
    end else if (clk_en) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 2; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_f_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  logic pd_run;      // power-down pin released
  logic sclk_f;      // filtered serial clock
  logic sclk_prev_q; // previous filtered serial clock
  logic sclk_fall;   // falling edge pulse
  logic sclk_rise;   // rising edge pulse

  assign pd_run = pin_f_q[0];
  assign sclk_f = pin_f_q[1];

  // serial clock edge finder; idles high so no false edge on reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b1;
    end else if (clk_en) begin
      sclk_prev_q <= sclk_f;
    end
  end

  assign sclk_fall = sclk_prev_q & ~sclk_f;
  assign sclk_rise = ~sclk_prev_q & sclk_f;

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  seq_state_e  state_q;    // current phase
  logic [22:0] tmr_q;      // oscillator start and conversion timer
  logic [3:0]  conv_cnt_q; // conversions since sampling began, saturating
  logic        settled;    // settling time has elapsed
  logic        conv_tick;  // a conversion completes this cycle
  logic        present;    // this conversion is shown to the host
  logic        pre_update; // last moment before the next update

  // phase machine; the pin held low forces everything back to off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_OFF;
    end else if (clk_en) begin
      if (!pd_run) begin
        state_q <= ST_OFF;
      end else begin
        case (state_q)
          ST_OFF: begin
            state_q <= ST_OSC_WAIT;
          end
          ST_OSC_WAIT: begin
            if (tmr_q == OSC_LAST) begin
              state_q <= ST_CONVERT;
            end
          end
          ST_CONVERT: begin
            state_q <= ST_CONVERT;
          end
          default: begin
            state_q <= ST_OFF;
          end
        endcase
      end
    end
  end

  // one timer serves both the start wait and the output period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmr_q <= 23'h00_0000;
    end else if (clk_en) begin
      if (!pd_run || state_q == ST_OFF) begin
        tmr_q <= 23'h00_0000;
      end else if (state_q == ST_OSC_WAIT && tmr_q == OSC_LAST) begin
        // sampling starts with a fresh period
        tmr_q <= 23'h00_0000;
      end else if (state_q == ST_CONVERT && tmr_q == CONV_LAST) begin
        tmr_q <= 23'h00_0000;
      end else begin
        tmr_q <= tmr_q + 23'h00_0001;
      end
    end
  end

  assign conv_tick  = (state_q == ST_CONVERT) && (tmr_q == CONV_LAST);
  assign pre_update = (state_q == ST_CONVERT) && (tmr_q == PRE_POINT);
  assign settled    = (conv_cnt_q > SETTLE_LAST);
  assign present    = conv_tick && (conv_cnt_q >= SETTLE_LAST);

  // conversion counter, stops once settled to stay small
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt_q <= 4'h0;
    end else if (clk_en) begin
      if (!pd_run) begin
        conv_cnt_q <= 4'h0;
      end else if (conv_tick && !settled) begin
        conv_cnt_q <= conv_cnt_q + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // result register and availability
  // ------------------------------------------------------------------
  code_t result_q; // latest conversion, offset binary
  logic  err_q;    // latest conversion out of range
  logic  avail_q;  // shown result not yet read or withdrawn

  // result register, rewritten by every conversion, settled or not
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= `SDC_RESULT_RST;
      err_q    <= 1'b0;
    end else if (clk_en) begin
      if (!pd_run) begin
        result_q <= `SDC_RESULT_RST;
        err_q    <= 1'b0;
      end else if (conv_tick) begin
        result_q <= to_offset_binary(filt_data);
        err_q    <= filt_range_err;
      end
    end
  end

  sdc_shift_if sh ();

  // availability: set by a shown result, dropped by read or pre-update
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avail_q <= 1'b0;
    end else if (clk_en) begin
      if (!pd_run) begin
        avail_q <= 1'b0;
      end else if (present) begin
        avail_q <= 1'b1;
      end else if (sh.done || pre_update) begin
        avail_q <= 1'b0;
      end
    end
  end

  assign sh.word      = {to_offset_binary(filt_data), `SDC_PAD_BITS, 1'b0, 1'b0,
                         filt_range_err, `SDC_IDENTITY, `SDC_PATTERN};
  assign sh.load      = present;
  // serial interface resets at every update and when withdrawn
  assign sh.clear     = !pd_run || conv_tick || pre_update;
  // reads only count while a result is on offer
  assign sh.sclk_fall = sclk_fall && avail_q;
  assign sh.sclk_rise = sclk_rise && avail_q;

  sdc_word_shifter u_shifter (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .sh      (sh)
  );

  // ------------------------------------------------------------------
  // data/ready pin
  // ------------------------------------------------------------------
  logic dout_q; // registered pin level
  logic oe_q;   // registered pin enable

  // line level: data bits during a read, low while on offer, else high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dout_q <= 1'b1;
      oe_q   <= 1'b0;
    end else if (clk_en) begin
      oe_q <= pd_run;
      if (!pd_run) begin
        dout_q <= 1'b1;
      end else if (sh.busy) begin
        dout_q <= sh.bit_out;
      end else if (avail_q && !sh.done) begin
        // low marks new data; not in the done cycle, or a false edge follows a read
        dout_q <= 1'b0;
      end else begin
        dout_q <= 1'b1;
      end
    end
  end

  assign dout_rdy_o  = dout_q;
  assign dout_rdy_oe = oe_q;

  // analog side controls follow the phase; dsp_clear follows the power-down pin
  assign osc_en    = (state_q != ST_OFF);
  assign mod_run   = (state_q == ST_CONVERT);
  assign dsp_clear = !pd_run;

  // ------------------------------------------------------------------
  // events, status, mask, register port
  // ------------------------------------------------------------------
  event_t ev;       // events this cycle
  event_t status_q; // sticky event bits
  event_t mask_q;   // interrupt enables
  logic   [31:0] rdata_q;
  logic   status_rd;

  assign ev[`SDC_ST_NEW]     = present;
  assign ev[`SDC_ST_READ]    = sh.done;
  // an unread result withdrawn counts as lost
  assign ev[`SDC_ST_OVERRUN] = pre_update && avail_q;
  assign ev[`SDC_ST_RANGE]   = present && filt_range_err;

  assign status_rd = reg_rd && (reg_addr == `SDC_REG_STATUS);

  // sticky bits; a read clears them but a new event in that cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= `SDC_STATUS_RST;
    end else if (clk_en) begin
      // pin low clears the sticky bits too
      status_q <= !pd_run ? `SDC_STATUS_RST : (ev | (status_rd ? `SDC_STATUS_RST : status_q));
    end
  end

  // mask register, the only writable one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= `SDC_MASK_RST;
    end else if (clk_en) begin
      if (!pd_run) begin
        mask_q <= `SDC_MASK_RST;
      end else if (reg_wr && reg_addr == `SDC_REG_MASK) begin
        mask_q <= reg_wdata[3:0];
      end
    end
  end

  // read data one cycle after the strobe, zero for unmapped offsets
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (!reg_rd) begin
        rdata_q <= 32'h0000_0000;
      end else if (reg_addr == `SDC_REG_STATUS) begin
        rdata_q <= {28'h000_0000, status_q};
      end else if (reg_addr == `SDC_REG_MASK) begin
        rdata_q <= {28'h000_0000, mask_q};
      end else if (reg_addr == `SDC_REG_RESULT) begin
        rdata_q <= {19'h0_0000, err_q, result_q};
      end else if (reg_addr == `SDC_REG_STATE) begin
        rdata_q <= {26'h000_0000, dout_q, oe_q, avail_q, settled, state_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign reg_rdata = rdata_q;
  // level interrupt while any enabled bit is set
  assign irq       = |(status_q & mask_q);
endmodule // sigma_delta_conversion_sequencer
`default_nettype wire

// ### sdc_seq_props.sv
// port checker for the conversion sequencer, bound at its top
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_seq_props #(
  parameter int unsigned CONV_CYCLES   = 400,
  parameter int unsigned SETTLE_CYCLES = 1200,
  parameter int unsigned OSC_CYCLES    = 50
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_down_reset_n,
  input wire logic sclk,
  input wire logic dout_rdy_o,
  input wire logic dout_rdy_oe,
  input wire logic osc_en,
  input wire logic mod_run,
  input wire logic dsp_clear
);
  localparam int PRE = `SDC_PRE_UPDATE_NS / `SDC_CLK_PERIOD_NS; // withdraw margin
  logic [31:0] osc_q;    // cycles spent starting the oscillator
  logic [31:0] run_q;    // cycles since sampling began
  logic [31:0] gap_q;    // cycles since last ready edge
  logic        seen_q;   // a ready edge seen since wake
  logic        prev_q;   // pin level one cycle ago
  logic        rdy_fall; // ready edge with the host idle
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // data bits move while sclk is low, so a fall with sclk high is a ready edge
  assign rdy_fall = dout_rdy_oe && sclk && prev_q && !dout_rdy_o;
  // sampling counter restarts when sampling stops; oscillator count holds once sampling begins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_q <= '0;
      run_q <= '0;
    end else begin
      osc_q <= !osc_en ? '0 : (mod_run ? osc_q : osc_q + 1);
      run_q <= mod_run ? run_q + 1 : '0;
    end
  end
  // spacing of ready edges; forgotten when the pin floats
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
      prev_q <= 1'b1;
    end else begin
      gap_q  <= (!dout_rdy_oe || rdy_fall) ? '0 : gap_q + 1;
      seen_q <= dout_rdy_oe && (seen_q || rdy_fall);
      prev_q <= dout_rdy_o;
    end
  end
  a_pd_tristate: assert property (!power_down_reset_n [*8] |-> !dout_rdy_oe)
    else $error("data pin driven during power-down");
  a_pd_clears_all: assert property (!power_down_reset_n [*8] |-> dsp_clear && !osc_en && !mod_run)
    else $error("logic not held clear during power-down");
  a_wake_pin_high: assert property ($rose(dout_rdy_oe) |-> dout_rdy_o)
    else $error("pin not high when driven again");
  a_osc_wait_high: assert property (dout_rdy_oe && osc_en && !mod_run |-> dout_rdy_o)
    else $error("ready shown before sampling began");
  a_osc_start_time: assert property ($rose(mod_run) |-> osc_q >= OSC_CYCLES - 2 && osc_q <= OSC_CYCLES + 2)
    else $error("sampling began at wrong time");
  a_first_settled: assert property (rdy_fall && !seen_q |-> run_q >= SETTLE_CYCLES - 2 && run_q <= SETTLE_CYCLES + 4)
    else $error("first ready edge not at settling time");
  a_output_rate: assert property (rdy_fall && seen_q |-> gap_q == CONV_CYCLES - 1)
    else $error("ready edges not one period apart");
  a_withdraw_window: assert property (seen_q && gap_q >= CONV_CYCLES - PRE + 4 && gap_q <= CONV_CYCLES - 3 |-> dout_rdy_o)
    else $error("pin low just before an update");
  c_periodic: cover property (rdy_fall && seen_q);
  c_sampling: cover property ($rose(mod_run));
  c_powerdown: cover property ($fell(dout_rdy_oe));
endmodule // sdc_seq_props
bind sigma_delta_conversion_sequencer sdc_seq_props #(.CONV_CYCLES(CONV_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES),
  .OSC_CYCLES(OSC_CYCLES)) props (.clk, .reset_n, .power_down_reset_n, .sclk, .dout_rdy_o, .dout_rdy_oe,
  .osc_en, .mod_run, .dsp_clear);
`default_nettype wire

// ### sdc_host_model.sv
// host controller model: power-down pin and 2-wire reads
`timescale 1ns/1ps
`default_nettype none
module sdc_host_model (
  input  wire logic clk,
  input  wire logic dout_rdy_o,
  input  wire logic dout_rdy_oe,
  output logic      power_down_reset_n,
  output logic      sclk
);
  import sdc_pkg::*;
  logic       last_q = 1'b0;  // last level the device drove
  logic       pin;            // resolved data pin level
  logic [1:0] sync_q = 2'h3;  // ready line in host clock
  logic       bad_pattern;    // corrupted transfer seen
  // pin idles high: power-up reset comes from reset_n alone
  initial begin
    power_down_reset_n = 1'b1;
    sclk = 1'b1;
    bad_pattern = 1'b0;
  end
  // no pull on the line: a floating pin shows the inverse of its last level
  always_ff @(posedge clk) if (dout_rdy_oe) last_q <= dout_rdy_o;
  assign pin = dout_rdy_oe ? dout_rdy_o : ~last_q;
  always_ff @(posedge clk) sync_q <= {sync_q[0], pin};
  // caller holds the level for at least 100 ns
  task automatic set_pd(input logic v);
    power_down_reset_n <= v;
  endtask
  // one frame at 125 ns period, msb first; clock stands high between frames
  task automatic read_word(output word_t w);
    for (int i = 0; i < 24; i++) begin
      sclk <= 1'b0;
      #62.5;
      w = {w[22:0], pin};
      sclk <= 1'b1;
      #62.5;
    end
    // flag a transfer whose pattern differs
    bad_pattern = (w[2:0] !== 3'h5);
  endtask
endmodule // sdc_host_model
`default_nettype wire

// ### tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.svh"
module tb;
  import sdc_pkg::*;
  localparam int CONV = 1200;  // shortened period, leaves room for a frame
  localparam int SETTLE = 3600; // three periods
  localparam int OSC = 50;      // shortened oscillator start
  logic clk, reset_n, clk_en, power_down_reset_n, sclk, dout_rdy_o, dout_rdy_oe;
  logic osc_en, mod_run, dsp_clear, filt_range_err, reg_wr, reg_rd, irq;
  code_t       filt_data;          // filter output driven by the bench
  logic [7:0]  reg_addr;           // register byte address
  logic [31:0] reg_wdata, reg_rdata, rd;
  word_t       w;                  // last frame read
  int          num_errors = 0, n_checks = 0, cyc = 0, n, tl;
  code_t       f_tab [4] = '{12'h800, 12'h000, 12'h7FF, 12'hC00}; // filter codes
  code_t       x_tab [4] = '{12'h000, 12'h800, 12'hFFF, 12'h400}; // expected codes
  logic        e_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};             // range errors
  sigma_delta_conversion_sequencer #(.CONV_CYCLES(CONV), .SETTLE_CYCLES(SETTLE), .OSC_CYCLES(OSC)) dut (
    .clk, .reset_n, .clk_en, .power_down_reset_n, .sclk, .dout_rdy_o, .dout_rdy_oe, .filt_data, .filt_range_err,
    .osc_en, .mod_run, .dsp_clear, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  sdc_host_model host (.clk, .dout_rdy_o, .dout_rdy_oe, .power_down_reset_n, .sclk);
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog; nonblocking so readers at the edge see a stable count
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      $display("Error at %0t: run too long", $time);
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait for the host's synchronised ready
  task automatic wait_ready(input int lim);
    n = 0;
    while (host.sync_q[1] !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("Error at %0t: no ready seen", $time);
    end
  endtask
  // wake sequence up to the first settled result
  task automatic power_up();
    int t0;
    t0 = cyc;
    repeat (12) @(posedge clk);
    chk({dout_rdy_oe, dout_rdy_o}, 2'h3, "pin high on wake");
    rd_reg(8'h0C, rd);
    chk(rd[1:0], 2'h1, "oscillator starting");
    while (cyc - t0 < OSC + CONV + 30) @(posedge clk);
    rd_reg(8'h08, rd);
    chk(rd[11:0], filt_data ^ 12'h800, "unsettled result stored");
    chk(dout_rdy_o, 1'b1, "no ready before settling");
    wait_ready(SETTLE);
    chk(32'(cyc - t0 >= OSC + SETTLE && cyc - t0 <= OSC + SETTLE + 12), 1, "first result time");
    $display("test wake done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    filt_data = 12'h800;
    filt_range_err = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk);
    chk({dout_rdy_oe, irq, osc_en, mod_run, dsp_clear, dout_rdy_o}, 6'h03, "quiet in reset");
    chk(reg_rdata, 32'h0, "read data idle");
    reset_n <= 1'b1;
    power_up();
    // coding table; each entry is read as a full frame
    for (int i = 0; i < 4; i++) begin
      if (i > 0) wait_ready(CONV + 40);
      if (i > 1) chk(32'(cyc - tl), CONV, "output period");
      tl = cyc;
      host.read_word(w);
      chk(w[23:12], x_tab[i], "offset binary code");
      chk(w, {x_tab[i], `SDC_PAD_BITS, 2'h0, e_tab[i], `SDC_IDENTITY, `SDC_PATTERN}, "frame layout");
      chk(host.bad_pattern, 1'b0, "check pattern");
      @(posedge clk);
      chk(dout_rdy_o, 1'b1, "pin high after read");
      rd_reg(8'h08, rd);
      chk(rd, {19'h0, e_tab[i], x_tab[i]}, "result register");
      rd_reg(8'h00, rd);
      chk(rd[`SDC_ST_READ], 1'b1, "read event");
      if (i < 3) begin
        @(posedge clk);
        filt_data <= f_tab[i + 1]; // step lands between ticks; stub filter settles at once
        filt_range_err <= e_tab[i + 1];
      end
    end
    $display("test coding done");
    // leave a result unread, masked first
    wr(8'h04, 32'h0);
    wait_ready(CONV + 40);
    tl = cyc;
    while (cyc - tl < CONV - 180) @(posedge clk);
    chk(dout_rdy_o, 1'b1, "unread result withdrawn");
    chk(irq, 1'b0, "masked event");
    wr(8'h04, 32'h4);
    rd_reg(8'h04, rd);
    chk(rd, 32'h4, "mask readback");
    chk(irq, 1'b1, "overrun interrupt");
    rd_reg(8'h00, rd);
    chk(rd[`SDC_ST_OVERRUN], 1'b1, "overrun flag");
    chk(irq, 1'b0, "cleared by read");
    rd_reg(8'h10, rd);
    chk(rd, 32'h0, "unmapped read");
    $display("test overrun done");
    // power-down in mid-run, held 30 cycles
    @(posedge clk);
    host.set_pd(1'b0);
    repeat (25) @(posedge clk);
    chk({dout_rdy_oe, osc_en, mod_run, dsp_clear}, 4'h1, "powered down");
    rd_reg(8'h04, rd);
    chk(rd, 32'h0, "mask cleared");
    rd_reg(8'h0C, rd);
    chk(rd[1:0], 2'h0, "sequencer off");
    @(posedge clk);
    host.set_pd(1'b1);
    power_up();
    $display("test power-down done");
    conclude();
  end
endmodule // tb
`default_nettype wire
